// file: core/sni_pkg.sv
// Purpose: constants for the sleep, normal-mode and inversion command block
// Assumes: 40 MHz pclk, APB register access, one opcode per write to the command register
// Notes: all wait figures are kept in milliseconds and turned into ticks of a 1 ms enable
// Function
// - Opcode 11h leaves sleep: converter, oscillator and panel scanning start.
// - Sleep exit does nothing when already out of sleep.
// - Once awake, only opcode 10h returns the device to sleep; software reset 01h also drops straight to sleep here.
// - Factory defaults reload during wake-up without visible disturbance.
// - Self-diagnostics run during the first 5 ms after sleep exit.
// - Awake state with booster on is reached within 120 ms of sleep exit.
// - Opcode 13h returns to normal mode, clearing partial and scroll.
// - Normal-mode command does nothing when normal mode is active.
// - Normal mode is active after power-on, software and hardware reset.
// - Opcode 20h leaves inversion, nothing else changes.
// - Inversion-off does nothing when inversion is already off.
// - Opcode 21h enters inversion, nothing else changes.
// - Inversion-on does nothing when inversion is already on.
// - Inversion is off after power-on, software and hardware reset.
// - In sleep the converter, oscillator and panel scanning are stopped.

package sni_pkg;

   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned OP_W          = 8;

   // Register byte offsets
   localparam logic [7:0]  CMD_OFF       = 8'h00;
   localparam logic [7:0]  STATUS_OFF    = 8'h04;
   localparam logic [7:0]  CTRL_OFF      = 8'h08;

   // Opcodes
   localparam logic [7:0]  OP_SW_RESET   = 8'h01;
   localparam logic [7:0]  OP_SLEEP_IN   = 8'h10;
   localparam logic [7:0]  OP_SLEEP_OUT  = 8'h11;
   localparam logic [7:0]  OP_NORMAL     = 8'h13;
   localparam logic [7:0]  OP_INV_OFF    = 8'h20;
   localparam logic [7:0]  OP_INV_ON     = 8'h21;

   // Status register bit positions
   localparam int unsigned ST_SLEEP_BIT  = 0;
   localparam int unsigned ST_NORMAL_BIT = 1;
   localparam int unsigned ST_PART_BIT   = 2;
   localparam int unsigned ST_SCROLL_BIT = 3;
   localparam int unsigned ST_INV_BIT    = 4;
   localparam int unsigned ST_BOOST_BIT  = 5;
   localparam int unsigned ST_OSC_BIT    = 6;
   localparam int unsigned ST_SCAN_BIT   = 7;
   localparam int unsigned ST_RELOAD_BIT = 8;
   localparam int unsigned ST_DIAG_BIT   = 9;
   localparam int unsigned ST_NOEFF_BIT  = 10;

   // Control register bit positions
   localparam int unsigned CT_PART_BIT   = 0;
   localparam int unsigned CT_SCROLL_BIT = 1;

   // Reset values of the mode flags
   localparam logic        SLEEP_RST     = 1'b1;
   localparam logic        NORMAL_RST    = 1'b1;
   localparam logic        PART_RST      = 1'b0;
   localparam logic        SCROLL_RST    = 1'b0;
   localparam logic        INV_RST       = 1'b0;

   // Timing
   localparam int unsigned CLK_FREQ_HZ   = 40_000_000;
   localparam int unsigned TICK_TIME_US  = 1000;
   localparam int unsigned TICK_CYCLES   = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
   localparam int unsigned TICK_W        = 16;
   localparam int unsigned MS_W          = 7;
   localparam int unsigned DIAG_MS       = 5;
   localparam int unsigned RELOAD_MS     = 15;
   localparam int unsigned WAKE_MS       = 120;
   localparam int unsigned SLEEP_IN_MS   = 120;

   typedef enum logic [3:0] {
      ST_ASLEEP  = 4'b0001,
      ST_WAKING  = 4'b0010,
      ST_AWAKE   = 4'b0100,
      ST_DOZING  = 4'b1000
   } sni_state_t;

endpackage : sni_pkg

// file: core/sni_tick.sv
// Purpose: 1 ms enable pulse divider
// Assumes: clr restarts the period so a sequence starts on a clean boundary
// Notes: tick is a one-cycle pulse every PERIOD cycles

`timescale 1ns/1ps
`default_nettype none

module sni_tick
   import sni_pkg::*;
#(
   parameter int unsigned PERIOD = TICK_CYCLES
) (
   input  wire logic pclk,     // Clock
   input  wire logic presetn,  // Async reset, active low
   input  wire logic clr,      // Restart the period
   output logic      tick      // One-cycle enable
);

   logic [TICK_W-1:0] cnt_q;
   logic [TICK_W-1:0] cnt_d;
   logic              tick_d;

   always_comb begin
      tick_d = 1'b0;
      cnt_d  = cnt_q + 1'b1;
      if (clr) begin
         cnt_d = '0;
      end else if (cnt_q == TICK_W'(PERIOD - 1)) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end

endmodule : sni_tick

`default_nettype wire

// file: core/sni_mode_ctrl.sv
// Purpose: sleep exit/enter, normal mode and inversion command handling behind APB
// Assumes: one opcode per APB write to the command register; host keeps its waits
// Notes: zero wait state slave; status shows every mode flag and supply enable

`timescale 1ns/1ps
`default_nettype none

module sni_mode_ctrl
   import sni_pkg::*;
#(
   parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
   input  wire logic              pclk,         // Clock, 40 MHz
   input  wire logic              presetn,      // Async reset, active low
   input  wire logic              psel,         // APB select
   input  wire logic              penable,      // APB access phase
   input  wire logic              pwrite,       // APB direction
   input  wire logic [ADDR_W-1:0] paddr,        // APB byte address
   input  wire logic [DATA_W-1:0] pwdata,       // APB write data
   input  wire logic [3:0]        pstrb,        // APB byte strobes
   output logic                   pready,       // APB ready
   output logic      [DATA_W-1:0] prdata,       // APB read data
   output logic                   pslverr,      // APB error, unmapped address
   output logic                   booster_en,   // DC/DC converter enable
   output logic                   osc_en,       // Display oscillator enable
   output logic                   scan_en,      // Panel scanning enable
   output logic                   reload_busy,  // Factory default reload running
   output logic                   diag_busy,    // Self-diagnostics running
   output logic                   invert_on,    // Display inversion active
   output logic                   normal_on,    // Normal display mode active
   output logic                   partial_on,   // Partial mode active
   output logic                   scroll_on,    // Scroll mode active
   output logic                   sleep_on      // Sleep flag
);

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Bus decode
   logic setup;
   logic access;
   logic wr_cmd;
   logic wr_ctrl;
   logic mapped;

   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign mapped  = hit(paddr, CMD_OFF) || hit(paddr, STATUS_OFF) || hit(paddr, CTRL_OFF);
   assign wr_cmd  = access && pwrite && pstrb[0] && hit(paddr, CMD_OFF);
   assign wr_ctrl = access && pwrite && pstrb[0] && hit(paddr, CTRL_OFF);
   // Zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   logic [OP_W-1:0] op;
   assign op = pwdata[OP_W-1:0];

   // Timebase
   logic tick;
   logic tick_clr;

   sni_tick #(
      .PERIOD (TICK_PERIOD)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (tick_clr),
      .tick    (tick)
   );

   // Sequencer state
   sni_state_t     state_q;
   sni_state_t     state_d;
   logic [MS_W-1:0] ms_q;
   logic [MS_W-1:0] ms_d;
   logic           sleep_q;
   logic           sleep_d;
   logic           normal_q;
   logic           normal_d;
   logic           part_q;
   logic           part_d;
   logic           scroll_q;
   logic           scroll_d;
   logic           inv_q;
   logic           inv_d;
   logic           noeff_q;
   logic           noeff_d;
   logic           boost_q;
   logic           boost_d;
   logic           reload_q;
   logic           reload_d;
   logic           diag_q;
   logic           diag_d;

   always_comb begin
      state_d  = state_q;
      ms_d     = ms_q;
      sleep_d  = sleep_q;
      normal_d = normal_q;
      part_d   = part_q;
      scroll_d = scroll_q;
      inv_d    = inv_q;
      noeff_d  = noeff_q;
      tick_clr = 1'b0;

      if (tick) begin
         ms_d = ms_q + 1'b1;
      end

      unique case (state_q)
         ST_WAKING: begin
            // Leave waking only after the full interval so the host sees a settled booster
            if (tick && ms_q == MS_W'(WAKE_MS - 1)) begin
               state_d = ST_AWAKE;
               sleep_d = 1'b0;
            end
         end
         ST_DOZING: begin
            if (tick && ms_q == MS_W'(SLEEP_IN_MS - 1)) begin
               state_d = ST_ASLEEP;
               sleep_d = 1'b1;
            end
         end
         ST_ASLEEP, ST_AWAKE: begin
            // Hold the count while idle; every sequence restarts it anyway
            ms_d = ms_q;
         end
         default: begin
            state_d = ST_ASLEEP;
            sleep_d = SLEEP_RST;
         end
      endcase

      if (wr_cmd) begin
         noeff_d = 1'b0;
         unique case (op)
            OP_SLEEP_OUT: begin
               if (state_q == ST_ASLEEP) begin
                  state_d  = ST_WAKING;
                  ms_d     = '0;
                  tick_clr = 1'b1;
               end else begin
                  // Also refused while waking or dozing so a transition never restarts
                  noeff_d = 1'b1;
               end
            end
            OP_SLEEP_IN: begin
               // Only this opcode starts the doze back to sleep; software reset drops straight to ST_ASLEEP
               if (state_q == ST_AWAKE) begin
                  state_d  = ST_DOZING;
                  ms_d     = '0;
                  tick_clr = 1'b1;
               end else begin
                  noeff_d = 1'b1;
               end
            end
            OP_NORMAL: begin
               if (normal_q) begin
                  noeff_d = 1'b1;
               end else begin
                  normal_d = 1'b1;
                  part_d   = 1'b0;
                  scroll_d = 1'b0;
               end
            end
            OP_INV_OFF: begin
               if (!inv_q) begin
                  noeff_d = 1'b1;
               end else begin
                  inv_d = 1'b0;
               end
            end
            OP_INV_ON: begin
               if (inv_q) begin
                  noeff_d = 1'b1;
               end else begin
                  inv_d = 1'b1;
               end
            end
            OP_SW_RESET: begin
               // Drops an unfinished wake or doze and restores power-on flags
               state_d  = ST_ASLEEP;
               sleep_d  = SLEEP_RST;
               normal_d = NORMAL_RST;
               part_d   = PART_RST;
               scroll_d = SCROLL_RST;
               inv_d    = INV_RST;
            end
            default: begin
               noeff_d = 1'b1;
            end
         endcase
      end

      // Partial and scroll entry belong to other commands; software sets them here
      if (wr_ctrl) begin
         part_d   = pwdata[CT_PART_BIT];
         scroll_d = pwdata[CT_SCROLL_BIT];
         normal_d = !(pwdata[CT_PART_BIT] || pwdata[CT_SCROLL_BIT]);
      end
   end

   // Supplies run from sleep exit until the doze interval has drained the panel
   always_comb begin
      boost_d  = (state_d != ST_ASLEEP);
      reload_d = (state_d == ST_WAKING) && (ms_d < MS_W'(RELOAD_MS));
      diag_d   = (state_d == ST_WAKING) && (ms_d < MS_W'(DIAG_MS));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= ST_ASLEEP;
         ms_q     <= '0;
         sleep_q  <= SLEEP_RST;
         normal_q <= NORMAL_RST;
         part_q   <= PART_RST;
         scroll_q <= SCROLL_RST;
         inv_q    <= INV_RST;
         noeff_q  <= 1'b0;
         boost_q  <= 1'b0;
         reload_q <= 1'b0;
         diag_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         ms_q     <= ms_d;
         sleep_q  <= sleep_d;
         normal_q <= normal_d;
         part_q   <= part_d;
         scroll_q <= scroll_d;
         inv_q    <= inv_d;
         noeff_q  <= noeff_d;
         boost_q  <= boost_d;
         reload_q <= reload_d;
         diag_q   <= diag_d;
      end
   end

   // Converter, oscillator and scanning start and stop together
   assign booster_en  = boost_q;
   assign osc_en      = boost_q;
   assign scan_en     = boost_q;
   assign reload_busy = reload_q;
   assign diag_busy   = diag_q;
   assign invert_on   = inv_q;
   assign normal_on   = normal_q;
   assign partial_on  = part_q;
   assign scroll_on   = scroll_q;
   assign sleep_on    = sleep_q;

   // Read data
   logic [DATA_W-1:0] status_w;
   logic [DATA_W-1:0] rd_d;
   logic [DATA_W-1:0] rd_q;
   logic [OP_W-1:0]   last_op_q;
   logic [OP_W-1:0]   last_op_d;

   always_comb begin
      status_w                = '0;
      status_w[ST_SLEEP_BIT]  = sleep_q;
      status_w[ST_NORMAL_BIT] = normal_q;
      status_w[ST_PART_BIT]   = part_q;
      status_w[ST_SCROLL_BIT] = scroll_q;
      status_w[ST_INV_BIT]    = inv_q;
      status_w[ST_BOOST_BIT]  = boost_q;
      status_w[ST_OSC_BIT]    = boost_q;
      status_w[ST_SCAN_BIT]   = boost_q;
      status_w[ST_RELOAD_BIT] = reload_q;
      status_w[ST_DIAG_BIT]   = diag_q;
      status_w[ST_NOEFF_BIT]  = noeff_q;
      last_op_d               = wr_cmd ? op : last_op_q;
      rd_d                    = rd_q;
      // Captured in the setup cycle so the zero-wait access phase sees stable data
      if (setup && !pwrite) begin
         // Unmapped reads return zero alongside pslverr
         rd_d = '0;
         if (hit(paddr, CMD_OFF)) begin
            rd_d[OP_W-1:0] = last_op_q;
         end else if (hit(paddr, STATUS_OFF)) begin
            rd_d = status_w;
         end else if (hit(paddr, CTRL_OFF)) begin
            rd_d[CT_PART_BIT]   = part_q;
            rd_d[CT_SCROLL_BIT] = scroll_q;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q      <= '0;
         last_op_q <= '0;
      end else begin
         rd_q      <= rd_d;
         last_op_q <= last_op_d;
      end
   end

   assign prdata = rd_q;

endmodule : sni_mode_ctrl

`default_nettype wire

// file: dv/sni_mode_props.sv
// Purpose: port checks on the mode command block
// Assumes: TICK_PERIOD equals that of the bound instance
// Notes: flags are judged two edges after the command write edge
`timescale 1ns/1ps
`default_nettype none
module sni_mode_props
   import sni_pkg::*;
#(
   parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
   input wire logic              pclk,        // Clock
   input wire logic              presetn,     // Reset, low
   input wire logic              psel,        // Select
   input wire logic              penable,     // Access
   input wire logic              pwrite,      // Direction
   input wire logic [ADDR_W-1:0] paddr,       // Address
   input wire logic [DATA_W-1:0] pwdata,      // Write data
   input wire logic [3:0]        pstrb,       // Strobes
   input wire logic              booster_en,  // Converter
   input wire logic              osc_en,      // Oscillator
   input wire logic              scan_en,     // Scanning
   input wire logic              reload_busy, // Reload
   input wire logic              diag_busy,   // Diagnostics
   input wire logic              invert_on,   // Inversion
   input wire logic              normal_on,   // Normal
   input wire logic              partial_on,  // Partial
   input wire logic              sleep_on     // Sleep
);
   localparam int WAKE_MAX = 121 * TICK_PERIOD;
   localparam int DIAG_MAX = 5 * TICK_PERIOD + 2;
   localparam int RLD_MAX  = 15 * TICK_PERIOD + 2;
   wire       cmd_wr = psel && penable && pwrite && pstrb[0] && paddr == CMD_OFF;
   // Counters stand in for long delay ranges, which would be far too slow to unroll
   int        wake_cyc;
   int        diag_cyc;
   int        rld_cyc;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cyc <= 0;
         diag_cyc <= 0;
         rld_cyc  <= 0;
      end else begin
         wake_cyc <= (booster_en && sleep_on) ? wake_cyc + 1 : 0;
         diag_cyc <= diag_busy ? diag_cyc + 1 : 0;
         rld_cyc  <= reload_busy ? rld_cyc + 1 : 0;
      end
   end
   wire [7:0] op     = pwdata[7:0];
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wake_start_a: assert property (
      cmd_wr && op == OP_SLEEP_OUT && sleep_on && !booster_en |-> ##2 booster_en && diag_busy)
      else $error("wake start missing");
   wake_noeff_a: assert property (
      cmd_wr && op == OP_SLEEP_OUT && !sleep_on |-> ##2 !diag_busy && !reload_busy)
      else $error("wake restarted");
   wake_time_a: assert property (
      wake_cyc <= WAKE_MAX) else $error("wake too slow");
   diag_len_a: assert property (
      diag_cyc <= DIAG_MAX) else $error("diag too long");
   reload_len_a: assert property (
      rld_cyc <= RLD_MAX) else $error("reload too long");
   en_tie_a: assert property (
      booster_en == osc_en && osc_en == scan_en && (booster_en || sleep_on))
      else $error("enables differ");
   inv_on_a: assert property (
      cmd_wr && op == OP_INV_ON |-> ##2 invert_on && normal_on == $past(normal_on, 2)
      && partial_on == $past(partial_on, 2)) else $error("inversion on wrong");
   inv_off_a: assert property (
      cmd_wr && op == OP_INV_OFF |-> ##2 !invert_on && normal_on == $past(normal_on, 2)
      && partial_on == $past(partial_on, 2)) else $error("inversion off wrong");
   normal_set_a: assert property (
      cmd_wr && op == OP_NORMAL |-> ##2 normal_on && !partial_on) else $error("normal wrong");
   rst_dflt_a: assert property (
      $rose(presetn) |-> sleep_on && normal_on && !invert_on && !booster_en)
      else $error("reset defaults wrong");
endmodule : sni_mode_props
bind sni_mode_ctrl sni_mode_props #(.TICK_PERIOD(TICK_PERIOD)) i_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .booster_en(booster_en), .osc_en(osc_en),
   .scan_en(scan_en), .reload_busy(reload_busy), .diag_busy(diag_busy),
   .invert_on(invert_on), .normal_on(normal_on), .partial_on(partial_on), .sleep_on(sleep_on));
`default_nettype wire

// file: dv/sni_host_model.sv
// Purpose: host side APB master issuing mode commands
// Assumes: one opcode per write, all byte strobes set
// Notes: address and data are inverted when idle so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module sni_host_model
   import sni_pkg::*;
#(
   parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
   input  wire logic              pclk,    // Clock
   input  wire logic              pready,  // Ready
   input  wire logic [DATA_W-1:0] prdata,  // Read data
   input  wire logic              pslverr, // Error
   output logic                   psel,    // Select
   output logic                   penable, // Access
   output logic                   pwrite,  // Direction
   output logic      [ADDR_W-1:0] paddr,   // Address
   output logic      [DATA_W-1:0] pwdata,  // Write data
   output logic      [3:0]        pstrb    // Strobes
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
   // Diagnostics end 5 ms after wake; sleep entry must finish before the next wake
   task automatic settle(input logic [7:0] op);
      if (op == OP_SLEEP_OUT) repeat (5 * TICK_PERIOD) @(posedge pclk);
      if (op == OP_SLEEP_IN) repeat (121 * TICK_PERIOD) @(posedge pclk);
      // Return off the edge so callers see settled outputs
      @(negedge pclk);
   endtask : settle
endmodule : sni_host_model
`default_nettype wire

// file: dv/sni_mode_ctrl_tb.sv
// Purpose: self-checking bench for the mode command block
// Assumes: tick period of 10 cycles, so 1 ms is 10 cycles
// Notes: fl packs sleep, normal, partial, scroll, invert, booster
`timescale 1ns/1ps
`default_nettype none
module sni_mode_ctrl_tb;
   import sni_pkg::*;
   localparam int TP = 10;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [3:0]        pstrb;
   logic              booster_en, osc_en, scan_en, reload_busy, diag_busy;
   logic              invert_on, normal_on, partial_on, scroll_on, sleep_on;
   logic [5:0]        fl;
   logic [31:0]       q;
   logic              e;
   int                error_cnt = 0, comparisons = 0, cyc = 0;
   assign fl = {sleep_on, normal_on, partial_on, scroll_on, invert_on, booster_en};
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   sni_mode_ctrl #(.TICK_PERIOD(TP)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .booster_en(booster_en),
      .osc_en(osc_en), .scan_en(scan_en), .reload_busy(reload_busy), .diag_busy(diag_busy),
      .invert_on(invert_on), .normal_on(normal_on), .partial_on(partial_on),
      .scroll_on(scroll_on), .sleep_on(sleep_on));
   sni_host_model #(.TICK_PERIOD(TP)) i_host (.pclk(pclk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] op, input logic [5:0] ef, input logic ne);
      i_host.xfer(1'b1, CMD_OFF, {24'h0, op}, q, e);
      repeat (2) @(negedge pclk);
      chk({26'h0, fl}, {26'h0, ef}, "flags");
      i_host.xfer(1'b0, STATUS_OFF, 32'h0, q, e);
      chk({31'h0, q[ST_NOEFF_BIT]}, {31'h0, ne}, "no effect bit");
   endtask : cmd
   task automatic t_modes();
      logic [7:0] ops [6] = '{OP_INV_ON, OP_INV_ON, OP_INV_OFF, OP_INV_OFF, OP_NORMAL, OP_NORMAL};
      logic [5:0] efl [6] = '{6'h2E, 6'h2E, 6'h2C, 6'h2C, 6'h30, 6'h30};
      i_host.xfer(1'b1, CTRL_OFF, 32'h3, q, e);
      i_host.xfer(1'b0, CTRL_OFF, 32'h0, q, e);
      chk(q, 32'h3, "ctrl readback");
      for (int i = 0; i < 6; i++) cmd(ops[i], efl[i], 1'(i % 2));
      cmd(OP_SLEEP_IN, 6'h30, 1'b1);
      cmd(8'hFF, 6'h30, 1'b1);
      i_host.xfer(1'b0, CMD_OFF, 32'h0, q, e);
      chk(q, 32'hFF, "last opcode");
   endtask : t_modes
   task automatic t_wake();
      int t0;
      t0 = cyc;
      cmd(OP_SLEEP_OUT, 6'h31, 1'b0);
      chk({30'h0, diag_busy, reload_busy}, 32'h3, "wake busy");
      i_host.settle(OP_SLEEP_OUT);
      chk({30'h0, diag_busy, reload_busy}, 32'h1, "diag end");
      while (sleep_on === 1'b1 && cyc - t0 < 130 * TP) @(negedge pclk);
      chk({31'h0, 1'(cyc - t0 >= 120 * TP && cyc - t0 <= 120 * TP + 12)}, 32'h1, "wake");
      cmd(OP_SLEEP_OUT, 6'h11, 1'b1);
      cmd(OP_INV_ON, 6'h13, 1'b0);
      cmd(OP_INV_OFF, 6'h11, 1'b0);
      cmd(OP_SLEEP_IN, 6'h11, 1'b0);
      i_host.settle(OP_SLEEP_IN);
      chk({26'h0, fl}, 32'h30, "asleep");
   endtask : t_wake
   task automatic t_resets();
      for (int k = 0; k < 2; k++) begin
         i_host.xfer(1'b1, CTRL_OFF, 32'h1, q, e);
         cmd(OP_INV_ON, 6'h2A, 1'b0);
         if (k == 0) i_host.xfer(1'b1, CMD_OFF, {24'h0, OP_SW_RESET}, q, e);
         else begin
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
         end
         repeat (2) @(negedge pclk);
         chk({26'h0, fl}, 32'h30, "reset flags");
      end
      i_host.xfer(1'b0, 8'h0C, 32'h0, q, e);
      chk({e, q[30:0]}, 32'h80000000, "unmapped read");
   endtask : t_resets
   task automatic final_report();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      i_host.xfer(1'b0, STATUS_OFF, 32'h0, q, e);
      chk(q, 32'h3, "reset status");
      t_modes();
      t_wake();
      t_resets();
      final_report();
   end
endmodule : sni_mode_ctrl_tb
`default_nettype wire
